// file: inc/fcs_defines.svh
`ifndef FCS_DEFINES_SVH
`define FCS_DEFINES_SVH
// clock and timing
`define FCS_CLK_NS        10
`define FCS_WE_MIN_NS     5
`define FCS_WE_MIN_CYC    ((`FCS_WE_MIN_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_SETTLE_US     1
`define FCS_SETTLE_CYC    (`FCS_SETTLE_US * 1000 / `FCS_CLK_NS)
`define FCS_PROG_US       10
`define FCS_PROG_CYC      (`FCS_PROG_US * 1000 / `FCS_CLK_NS)
`define FCS_ERASE_MS      1000
`define FCS_ERASE_CYC     (`FCS_ERASE_MS * 1000000 / `FCS_CLK_NS)
`define FCS_PHASE_CYC     4
`define FCS_READ_STB_CYC  8
// address layout
`define FCS_ADDR_W        19
`define FCS_ROW_W         11
`define FCS_COL_W         8
`define FCS_BLK_MSB       18
`define FCS_BLK_LSB       16
`define FCS_UNLOCK_A1     16'h5555
`define FCS_UNLOCK_A2     16'h2AAA
// command codes
`define FCS_CMD_AA        8'hAA
`define FCS_CMD_55        8'h55
`define FCS_CMD_ERASE     8'h80
`define FCS_CMD_PROG      8'hA0
`define FCS_CMD_ID_ENTRY  8'h90
`define FCS_CMD_ID_EXIT   8'hF0
`define FCS_CMD_CHIP      8'h10
`define FCS_CMD_BLOCK_A   8'h30
`define FCS_CMD_BLOCK_B   8'h50
// identification offsets (low address bits)
`define FCS_ID_MANUF      2'h0
`define FCS_ID_DEVICE     2'h1
`define FCS_ID_CONT       2'h3
// status bit positions and reset values
`define FCS_POLL_BIT      7
`define FCS_TOGGLE_BIT    6
`define FCS_DQ_IDLE       8'hFF
`define FCS_ERASED        8'hFF
`endif

// file: inc/fcs_link_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
interface fcs_link_if;
  logic        rc_n;
  logic [10:0] addr_mux;
  logic        we_n;
  logic        oe_n;
  logic [7:0]  dq_host;
  logic        dq_host_oe;
  logic [7:0]  dq_dev;
  logic        dq_dev_oe;
  logic [7:0]  dq_level;
  // bus level with a pull-up when nobody drives
  assign dq_level = dq_dev_oe ? dq_dev :
                    (dq_host_oe ? dq_host : `FCS_DQ_IDLE);
  modport device (input rc_n, addr_mux, we_n, oe_n, dq_level,
                  output dq_dev, dq_dev_oe);
  modport host (output rc_n, addr_mux, we_n, oe_n, dq_host, dq_host_oe,
                input dq_level);
endinterface // fcs_link_if
`default_nettype wire

// file: inc/fcs_pkg.sv
package fcs_pkg;
  typedef enum logic [2:0] {
    FCS_OP_READ,
    FCS_OP_PROGRAM,
    FCS_OP_BLOCK_ERASE,
    FCS_OP_CHIP_ERASE,
    FCS_OP_ID_ENTRY,
    FCS_OP_ID_EXIT
  } fcs_op_t;
  typedef enum logic [1:0] {
    FCS_JOB_PROGRAM,
    FCS_JOB_BLOCK_ERASE,
    FCS_JOB_CHIP_ERASE
  } fcs_job_t;
endpackage

// file: rtl/fcs_flash_device.sv
// Operation
// - chip erase only in multiplexed mode
// - chip erase ends 10H at 5555H
// - erase starts at sixth strobe rise
// - busy ignores commands, reads give status
// - program polling bit inverted until done
// - full word valid one microsecond after
// - erase polling bit zero, then one
// - polling valid after fourth/sixth strobe
// - host polls inside valid address range
// - toggle bit flips per read while busy
// - toggle valid after fourth/sixth strobe
// - host rereads twice before trusting done
// - ignore write strobes narrower than 5ns
// - output enable low inhibits writes
// - unlock prefix required except for the short F0H exit
// - bad cycle aborts to read mode
// - block erase ends 30H or 50H
// - program: prefix, A0H, address and byte
// - id entry 90H; exit F0H forms
// - host sends sequences as consecutive cycles
// - id mode returns identification codes
// - row on select fall, column on rise
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_flash_device #(
  parameter int         ERASE_CYC = `FCS_ERASE_CYC,
  parameter logic [7:0] MANUF_ID  = 8'h5A, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'hC3, // arbitrary value
  parameter logic [7:0] CONT_ID   = 8'h11  // arbitrary value
) (
  // clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst_n,
  // programmer link
  fcs_link_if.device link,
  // user side
  input  wire logic  aa_mux_mode,
  output logic       busy,
  output logic       id_mode
);
  localparam int SW = 23;
  logic [SW-1:0] pins_s;
  logic          rc_s;
  logic [10:0]   am_s;
  logic          we_s;
  logic          oe_s;
  logic [7:0]    dq_s;
  logic          mode_s;
  fcs_sync #(.WIDTH(SW), .INIT({1'b1, 11'h000, 2'h3, 8'hFF, 1'b0})) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({link.rc_n, link.addr_mux, link.we_n, link.oe_n,
                link.dq_level, aa_mux_mode}),
    .q        (pins_s)
  );
  assign {rc_s, am_s, we_s, oe_s, dq_s, mode_s} = pins_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_U1, ST_U2, ST_PROG, ST_E3, ST_E4, ST_E5, ST_BUSY
  } fcs_state_t;

  fcs_state_t         st_reg;
  fcs_state_t         st_next;
  fcs_pkg::fcs_job_t  job_reg;
  fcs_pkg::fcs_job_t  job_next;
  logic               rc_d_reg;
  logic               we_d_reg;
  logic               oe_d_reg;
  logic [10:0]        row_reg;
  logic [7:0]         col_reg;
  logic [1:0]         we_low_reg;
  logic [18:0]        job_addr_reg;
  logic [7:0]         job_data_reg;
  logic [31:0]        busy_cnt_reg;
  logic [7:0]         settle_reg;
  logic               tog_reg;
  logic               id_reg;
  logic [7:0]         dq_reg;
  logic               dq_oe_reg;
  logic               start_job;
  logic               id_set;
  logic               id_clr;

  // edge detection on synchronised pins
  wire        rc_fall  = rc_d_reg & ~rc_s;
  wire        rc_rise  = ~rc_d_reg & rc_s;
  wire        oe_fall  = oe_d_reg & ~oe_s;
  wire [18:0] addr     = {col_reg, row_reg};
  // strobe must have been low long enough with output enable high
  wire        we_long  = we_low_reg >= 2'(`FCS_WE_MIN_CYC);
  wire        wr       = ~we_d_reg & we_s & we_long & oe_s;
  wire        a1       = addr[15:0] == `FCS_UNLOCK_A1;
  wire        a2       = addr[15:0] == `FCS_UNLOCK_A2;
  wire        is_aa    = dq_s == `FCS_CMD_AA;
  wire        is_55    = dq_s == `FCS_CMD_55;
  wire        is_f0    = dq_s == `FCS_CMD_ID_EXIT;
  wire        is_block = (dq_s == `FCS_CMD_BLOCK_A) |
                         (dq_s == `FCS_CMD_BLOCK_B);
  wire        is_chip  = (dq_s == `FCS_CMD_CHIP) & a1 & mode_s;
  wire        job_prog = job_reg == fcs_pkg::FCS_JOB_PROGRAM;
  wire [31:0] job_len  = job_prog ? 32'(`FCS_PROG_CYC) : 32'(ERASE_CYC);
  wire        done     = (st_reg == ST_BUSY) &&
                         (busy_cnt_reg == job_len - 32'h1);

  always_comb begin
    st_next   = st_reg;
    job_next  = job_reg;
    start_job = 1'b0;
    id_set    = 1'b0;
    id_clr    = 1'b0;
    if (done) begin
      st_next = ST_IDLE;
    end
    if (wr) begin
      case (st_reg)
        ST_IDLE: begin
          if (is_aa && a1) begin
            st_next = ST_U1;
          end else if (is_f0) begin
            id_clr = 1'b1;
          end
        end
        ST_U1: st_next = (is_55 && a2) ? ST_U2 : ST_IDLE;
        ST_U2: begin
          st_next = ST_IDLE;
          if (a1 && dq_s == `FCS_CMD_PROG) begin
            st_next = ST_PROG;
          end else if (a1 && dq_s == `FCS_CMD_ERASE) begin
            st_next = ST_E3;
          end else if (a1 && dq_s == `FCS_CMD_ID_ENTRY) begin
            id_set = 1'b1;
          end else if (a1 && is_f0) begin
            id_clr = 1'b1;
          end
        end
        ST_PROG: begin
          st_next   = ST_BUSY;
          job_next  = fcs_pkg::FCS_JOB_PROGRAM;
          start_job = 1'b1;
        end
        ST_E3: st_next = (is_aa && a1) ? ST_E4 : ST_IDLE;
        ST_E4: st_next = (is_55 && a2) ? ST_E5 : ST_IDLE;
        ST_E5: begin
          st_next = ST_IDLE;
          if (is_block) begin
            st_next   = ST_BUSY;
            job_next  = fcs_pkg::FCS_JOB_BLOCK_ERASE;
            start_job = 1'b1;
          end else if (is_chip) begin
            st_next   = ST_BUSY;
            job_next  = fcs_pkg::FCS_JOB_CHIP_ERASE;
            start_job = 1'b1;
          end
        end
        // a write landing on the last busy cycle must not undo completion
        ST_BUSY: job_next = job_reg;
        default: st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= ST_IDLE;
      job_reg    <= fcs_pkg::FCS_JOB_PROGRAM;
      rc_d_reg   <= 1'b1;
      we_d_reg   <= 1'b1;
      oe_d_reg   <= 1'b1;
      we_low_reg <= 2'h0;
    end else begin
      st_reg     <= st_next;
      job_reg    <= job_next;
      rc_d_reg   <= rc_s;
      we_d_reg   <= we_s;
      oe_d_reg   <= oe_s;
      if (we_s || !oe_s) begin
        we_low_reg <= 2'h0;
      end else if (!we_long) begin
        we_low_reg <= we_low_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      row_reg <= 11'h000;
      col_reg <= 8'h00;
    end else begin
      if (rc_fall) begin
        row_reg <= am_s;
      end
      if (rc_rise) begin
        col_reg <= am_s[7:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      job_addr_reg <= 19'h00000;
      job_data_reg <= 8'h00;
      busy_cnt_reg <= 32'h0;
      settle_reg   <= 8'h00;
      tog_reg      <= 1'b0;
      id_reg       <= 1'b0;
    end else begin
      if (start_job) begin
        job_addr_reg <= addr;
        job_data_reg <= dq_s;
        busy_cnt_reg <= 32'h0;
      end else if (st_reg == ST_BUSY) begin
        busy_cnt_reg <= busy_cnt_reg + 32'h1;
      end
      if (done) begin
        settle_reg <= 8'(`FCS_SETTLE_CYC);
      end else if (settle_reg != 8'h00) begin
        settle_reg <= settle_reg - 8'h01;
      end
      if (st_reg == ST_BUSY && oe_fall) begin
        tog_reg <= ~tog_reg;
      end
      if (id_set) begin
        id_reg <= 1'b1;
      end else if (id_clr) begin
        id_reg <= 1'b0;
      end
    end
  end

  // small cell store: one byte per block and low address bit
  logic [7:0] mem_q [0:15];
  wire  [3:0] rd_idx  = {addr[`FCS_BLK_MSB:`FCS_BLK_LSB], addr[0]};
  wire  [3:0] job_idx = {job_addr_reg[`FCS_BLK_MSB:`FCS_BLK_LSB],
                         job_addr_reg[0]};
  genvar e;
  generate
    for (e = 0; e < 16; e++) begin : g_cell
      logic [7:0] cell_reg;
      wire hit = (job_reg == fcs_pkg::FCS_JOB_CHIP_ERASE) ||
                 ((job_reg == fcs_pkg::FCS_JOB_BLOCK_ERASE) &&
                  job_idx[3:1] == 3'(e >> 1)) ||
                 (job_prog && job_idx == 4'(e));
      // programming only clears bits, as in the real array
      wire [7:0] val = job_prog ? (cell_reg & job_data_reg) : `FCS_ERASED;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          cell_reg <= `FCS_ERASED;
        end else if (done && hit) begin
          cell_reg <= val;
        end
      end
      assign mem_q[e] = cell_reg;
    end
  endgenerate

  // read word selection
  wire [7:0] arr_q   = mem_q[rd_idx];
  wire       poll    = job_prog ? ~job_data_reg[`FCS_POLL_BIT] : 1'b0;
  wire [7:0] stat_q  = {poll, tog_reg, 6'h00};
  wire [7:0] id_q    = (addr[1:0] == `FCS_ID_MANUF)  ? MANUF_ID :
                       (addr[1:0] == `FCS_ID_DEVICE) ? DEVICE_ID :
                       (addr[1:0] == `FCS_ID_CONT)   ? CONT_ID : 8'h00;
  wire [7:0] rd_word = (st_reg == ST_BUSY) ? stat_q :
                       (settle_reg != 8'h00) ? {arr_q[7], 7'h00} :
                       id_reg ? id_q : arr_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_reg    <= `FCS_DQ_IDLE;
      dq_oe_reg <= 1'b0;
    end else begin
      dq_reg    <= rd_word;
      dq_oe_reg <= ~oe_s & we_s;
    end
  end

  assign link.dq_dev    = dq_reg;
  assign link.dq_dev_oe = dq_oe_reg;
  assign busy           = st_reg == ST_BUSY;
  assign id_mode        = id_reg;
endmodule // fcs_flash_device
`default_nettype wire

// file: rtl/fcs_flash_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.svh"
module fcs_flash_host (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // programmer link
  fcs_link_if.host             link,
  // command port
  input  wire logic            cmd_valid,
  output logic                 cmd_ready,
  input  wire fcs_pkg::fcs_op_t cmd_op,
  input  wire logic [18:0]     cmd_addr,
  input  wire logic [7:0]      cmd_data,
  // answer port
  output logic                 rsp_valid,
  output logic [7:0]           rsp_data
);
  typedef enum logic [3:0] {
    H_IDLE, H_ROW, H_RCL, H_COL, H_RCH, H_STB, H_REC, H_SETTLE, H_RSP
  } fcs_hstate_t;

  fcs_hstate_t      st_reg;
  fcs_pkg::fcs_op_t op_reg;
  logic [18:0]      addr_reg;
  logic [7:0]       data_reg;
  logic [2:0]       step_reg;
  logic [7:0]       cnt_reg;
  logic             poll_reg;
  logic             final_reg;
  logic             have_prev_reg;
  logic             prev_tog_reg;
  logic             stable_reg;
  logic [7:0]       rd_reg;
  logic [7:0]       dq_s;

  fcs_sync #(.WIDTH(8), .INIT(`FCS_DQ_IDLE)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (link.dq_level),
    .q        (dq_s)
  );

  wire op_prog  = op_reg == fcs_pkg::FCS_OP_PROGRAM;
  wire op_block = op_reg == fcs_pkg::FCS_OP_BLOCK_ERASE;
  wire op_chip  = op_reg == fcs_pkg::FCS_OP_CHIP_ERASE;
  wire op_exit  = op_reg == fcs_pkg::FCS_OP_ID_EXIT;
  wire rd_cyc   = poll_reg | final_reg | (op_reg == fcs_pkg::FCS_OP_READ);
  wire [2:0] nsteps = (op_block | op_chip) ? 3'h6 :
                      op_prog ? 3'h4 : op_exit ? 3'h1 : 3'h3;
  wire last = step_reg == nsteps - 3'h1;
  // sequence cycles go out back to back with no reads between
  wire [18:0] seq_addr = (op_exit || (last && (op_prog || op_block))) ?
                         addr_reg :
                         (step_reg == 3'h1 || step_reg == 3'h4) ?
                         {3'h0, `FCS_UNLOCK_A2} : {3'h0, `FCS_UNLOCK_A1};
  // block erase sends the caller's final code, so both codes can be used
  wire [7:0] seq_data = op_exit ? `FCS_CMD_ID_EXIT :
                        (step_reg == 3'h0) ? `FCS_CMD_AA :
                        (step_reg == 3'h3) ?
                        (op_prog ? data_reg : `FCS_CMD_AA) :
                        (step_reg == 3'h1 || step_reg == 3'h4) ? `FCS_CMD_55 :
                        (step_reg == 3'h2) ?
                        (op_prog ? `FCS_CMD_PROG :
                         (op_block | op_chip) ? `FCS_CMD_ERASE :
                         `FCS_CMD_ID_ENTRY) :
                        op_block ? data_reg : `FCS_CMD_CHIP;
  // polling stays on the target, or on 5555H for chip erase, always inside the array
  wire [18:0] cyc_addr = (rd_cyc && op_chip) ? {3'h0, `FCS_UNLOCK_A1} :
                         rd_cyc ? addr_reg : seq_addr;
  wire [7:0] ph_len = (st_reg == H_STB && rd_cyc) ? 8'(`FCS_READ_STB_CYC) :
                      (st_reg == H_SETTLE) ? 8'(`FCS_SETTLE_CYC) :
                      8'(`FCS_PHASE_CYC);
  wire ph_end  = cnt_reg == ph_len - 8'h01;
  wire tog_now = rd_reg[`FCS_TOGGLE_BIT];
  wire steady  = have_prev_reg && (tog_now == prev_tog_reg);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= H_IDLE;
      op_reg        <= fcs_pkg::FCS_OP_READ;
      addr_reg      <= 19'h00000;
      data_reg      <= 8'h00;
      step_reg      <= 3'h0;
      cnt_reg       <= 8'h00;
      poll_reg      <= 1'b0;
      final_reg     <= 1'b0;
      have_prev_reg <= 1'b0;
      prev_tog_reg  <= 1'b0;
      stable_reg    <= 1'b0;
      rd_reg        <= `FCS_DQ_IDLE;
    end else begin
      cnt_reg <= (st_reg == H_IDLE || ph_end) ? 8'h00 : cnt_reg + 8'h01;
      if (st_reg == H_STB && rd_cyc && ph_end) begin
        rd_reg <= dq_s;
      end
      case (st_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            st_reg    <= H_ROW;
            op_reg    <= cmd_op;
            addr_reg  <= cmd_addr;
            data_reg  <= cmd_data;
            step_reg  <= 3'h0;
            poll_reg  <= 1'b0;
            final_reg <= 1'b0;
          end
        end
        H_ROW:  st_reg <= ph_end ? H_RCL : st_reg;
        H_RCL:  st_reg <= ph_end ? H_COL : st_reg;
        H_COL:  st_reg <= ph_end ? H_RCH : st_reg;
        H_RCH:  st_reg <= ph_end ? H_STB : st_reg;
        H_STB:  st_reg <= ph_end ? H_REC : st_reg;
        H_REC: begin
          if (ph_end) begin
            st_reg <= H_ROW;
            if (final_reg || (!poll_reg && rd_cyc)) begin
              st_reg <= H_RSP;
            end else if (!poll_reg && !last) begin
              step_reg <= step_reg + 3'h1;
            end else if (!poll_reg) begin
              if (op_prog || op_block || op_chip) begin
                poll_reg      <= 1'b1;
                have_prev_reg <= 1'b0;
                stable_reg    <= 1'b0;
              end else begin
                st_reg <= H_RSP;
              end
            end else begin
              // trust completion only after two matching rereads
              have_prev_reg <= 1'b1;
              prev_tog_reg  <= tog_now;
              stable_reg    <= steady;
              if (steady && stable_reg) begin
                st_reg   <= H_SETTLE;
                poll_reg <= 1'b0;
              end
            end
          end
        end
        H_SETTLE: begin
          if (ph_end) begin
            st_reg    <= H_ROW;
            final_reg <= 1'b1;
          end
        end
        H_RSP:   st_reg <= H_IDLE;
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  // pin decode from the state flop; each level holds a whole phase
  assign cmd_ready       = st_reg == H_IDLE;
  assign rsp_valid       = st_reg == H_RSP;
  assign rsp_data        = rd_reg;
  assign link.rc_n       = ~(st_reg == H_RCL || st_reg == H_COL);
  assign link.addr_mux   = (st_reg == H_COL || st_reg == H_RCH ||
                            st_reg == H_STB || st_reg == H_REC) ?
                           {3'h0, cyc_addr[18:11]} : cyc_addr[10:0];
  assign link.we_n       = ~(st_reg == H_STB && !rd_cyc);
  assign link.oe_n       = ~(st_reg == H_STB && rd_cyc);
  assign link.dq_host    = seq_data;
  assign link.dq_host_oe = !rd_cyc && (st_reg == H_STB || st_reg == H_REC);
endmodule // fcs_flash_host
`default_nettype wire

// file: rtl/fcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= INIT[i];
          sync_reg[i] <= INIT[i];
        end else begin
          meta_reg[i] <= d[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
  assign q = sync_reg;
endmodule // fcs_sync
`default_nettype wire

// file: sim/fcs_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_link_asserts (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // link wires
  input wire logic        rc_n,
  input wire logic [10:0] addr_mux,
  input wire logic        we_n,
  input wire logic        oe_n,
  input wire logic [7:0]  dq_host,
  input wire logic        dq_host_oe,
  input wire logic [7:0]  dq_dev,
  input wire logic        dq_dev_oe,
  // device status
  input wire logic        busy,
  input wire logic        id_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic tog_reg;
  logic tog_ok_reg;
  // toggle bit of the last read, valid only if that read ended while busy
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tog_reg    <= 1'b0;
      tog_ok_reg <= 1'b0;
    end else if ($fell(dq_dev_oe)) begin
      tog_reg    <= $past(dq_dev[6]);
      tog_ok_reg <= busy;
    end
  end
  no_clash_a: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive the data bus");
  write_inhibit_a: assert property (!we_n |-> oe_n)
    else $error("write strobe during output enable");
  write_strobe_a: assert property ($fell(we_n) |-> (!we_n)[*4] ##1 we_n)
    else $error("write strobe width wrong");
  read_strobe_a: assert property ($fell(oe_n) |-> (!oe_n)[*8] ##1 oe_n)
    else $error("read strobe width wrong");
  dev_drive_a: assert property ($fell(oe_n) |-> ##3 dq_dev_oe)
    else $error("device late to drive read data");
  dev_release_a: assert property (dq_dev_oe |-> !$past(oe_n, 3))
    else $error("device drives without output enable");
  strobe_addr_a: assert property (!we_n |-> rc_n && $stable(addr_mux)
    && dq_host_oe && $stable(dq_host))
    else $error("address or data moved under write strobe");
  busy_bits_a: assert property (busy && $past(busy, 3) && dq_dev_oe
    |-> dq_dev[5:0] == 6'h00)
    else $error("array data leaked while busy");
  toggle_flip_a: assert property ($fell(dq_dev_oe) && busy && tog_ok_reg
    |-> $past(dq_dev[6]) != tog_reg)
    else $error("toggle bit did not flip");
  id_hold_a: assert property (busy |-> $stable(id_mode))
    else $error("mode changed while busy");
  busy_min_a: assert property ($rose(busy) |-> busy[*8])
    else $error("operation ended too early");
endmodule // fcs_link_asserts
`default_nettype wire

// file: sim/flash_command_status_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module flash_command_status_sequencer_bench;
  // identification values are arbitrary
  localparam logic [7:0] IDS [4] = '{8'h5A, 8'hC3, 8'h00, 8'h11};
  logic             core_clk;
  logic             rst_n;
  logic             aa_mux_mode;
  logic             busy;
  logic             id_mode;
  logic             cmd_valid;
  logic             cmd_ready;
  fcs_pkg::fcs_op_t cmd_op;
  logic [18:0]      cmd_addr;
  logic [7:0]       cmd_data;
  logic             rsp_valid;
  logic [7:0]       rsp_data;
  logic [7:0]       mem [16];
  int               miscompares;
  int               tests_run;
  int               cycles;
  fcs_link_if link ();
  // short erase keeps the run brief
  fcs_flash_device #(.ERASE_CYC(200), .MANUF_ID(IDS[0]),
    .DEVICE_ID(IDS[1]), .CONT_ID(IDS[3])) u_fcs_flash_device (
    .core_clk(core_clk), .rst_n(rst_n), .link(link.device),
    .aa_mux_mode(aa_mux_mode), .busy(busy), .id_mode(id_mode));
  fcs_flash_host u_fcs_flash_host (
    .core_clk(core_clk), .rst_n(rst_n), .link(link.host),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  fcs_link_asserts u_fcs_link_asserts (
    .core_clk(core_clk), .rst_n(rst_n), .rc_n(link.rc_n),
    .addr_mux(link.addr_mux), .we_n(link.we_n), .oe_n(link.oe_n),
    .dq_host(link.dq_host), .dq_host_oe(link.dq_host_oe),
    .dq_dev(link.dq_dev), .dq_dev_oe(link.dq_dev_oe), .busy(busy),
    .id_mode(id_mode));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // a hang stops here instead of running forever
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [3:0] idx(input logic [18:0] a);
    return {a[18:16], a[0]};
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input fcs_pkg::fcs_op_t op, input logic [18:0] a,
                     input logic [7:0] d);
    while (cmd_ready !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [18:0] a);
    run(fcs_pkg::FCS_OP_READ, a, 8'h00);
    chk_byte(rsp_data, mem[idx(a)]);
  endtask
  initial begin
    logic [18:0] a;
    logic [7:0]  d;
    tests_run = 0;
    miscompares = 0;
    cycles = 0;
    rst_n = 1'b0;
    aa_mux_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = fcs_pkg::FCS_OP_READ;
    cmd_addr = 19'h00000;
    cmd_data = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
    void'($urandom(32'hD7380563));
    repeat (8) @(posedge core_clk);
    #1 rst_n = 1'b1;
    @(posedge core_clk);
    #1;
    rd(19'($urandom));
    run(fcs_pkg::FCS_OP_ID_ENTRY, 19'h00000, 8'h00);
    chk_bit(id_mode, 1'b1);
    for (int i = 0; i < 4; i++) begin
      run(fcs_pkg::FCS_OP_READ, {17'($urandom), 2'(i)}, 8'h00);
      chk_byte(rsp_data, IDS[i]);
    end
    run(fcs_pkg::FCS_OP_ID_EXIT, 19'($urandom), 8'h00);
    chk_bit(id_mode, 1'b0);
    // first pass programs zero, last one lands under the polled address
    for (int i = 0; i < 7; i++) begin
      a = (i == 6) ? 19'h00001 : 19'($urandom);
      d = (i == 0) ? 8'h00 : 8'($urandom);
      run(fcs_pkg::FCS_OP_PROGRAM, a, d);
      mem[idx(a)] &= d;
      chk_byte(rsp_data, mem[idx(a)]);
      chk_bit(busy, 1'b0);
      rd(a);
    end
    for (int i = 0; i < 2; i++) begin
      a = {a[18:16], 16'($urandom)};
      run(fcs_pkg::FCS_OP_BLOCK_ERASE, a, i ? 8'h50 : 8'h30);
      mem[{a[18:16], 1'b0}] = 8'hFF;
      mem[{a[18:16], 1'b1}] = 8'hFF;
      chk_byte(rsp_data, 8'hFF);
      rd(a ^ 19'h00001);
      a = 19'($urandom);
      run(fcs_pkg::FCS_OP_PROGRAM, a, 8'h3C);
      mem[idx(a)] &= 8'h3C;
    end
    // programmer mode off: the erase must change nothing
    run(fcs_pkg::FCS_OP_CHIP_ERASE, 19'h05555, 8'h10);
    chk_byte(rsp_data, mem[1]);
    aa_mux_mode = 1'b1;
    run(fcs_pkg::FCS_OP_CHIP_ERASE, 19'h05555, 8'h10);
    foreach (mem[i]) mem[i] = 8'hFF;
    chk_byte(rsp_data, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      rd({3'(i >> 1), 15'($urandom), 1'(i)});
    end
    test_done();
  end
endmodule // flash_command_status_sequencer_bench
`default_nettype wire
